// [hdl/aorc_top.sv]
// Behaviour
// - restore bit copies saved image to host registers, then self-clears.
// - save bit stores host image, then uploads config, then self-clears.
// - setting upload bit copies both config words to live config.
// - direct read with access enabled puts array byte into read data.
// - direct read acts only while direct access enable is one.
// - automatic save and restore happen only while enable is zero.
// - retained image covers the listed configuration registers.
// - only the low word of tx frame control is kept.
// - sniff bit 0 is not kept and comes back as zero.
// - only the delimiter length octet of user sfd is kept.
// - tx antenna delay is not kept; host reprograms after wake.
// - first power control keeps only bits 23, 15, 12, 11, 6.
// - second power control keeps all but the kilohertz divider.
// - led control keeps only blink enable; blink time reverts.
// - 8-bit read data register at sub-address 0x03.
// - 8-bit address register selects the direct read location.
`timescale 1ns/1ps
`default_nettype none
module aorc_top #(
  parameter int IMG_N = aorc_pkg::IMG_BYTES,
  parameter int DEPTH = aorc_pkg::ARR_DEPTH
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire aorc_pkg::aorc_req_t bus_i,
  output logic [7:0] rdata_o,
  input wire logic [IMG_N*8-1:0] user_cfg_i,
  input wire logic [31:0] retn_cfg0_i,
  input wire logic [31:0] retn_cfg1_i,
  input wire logic sleep_entry_i,
  input wire logic wake_i,
  output aorc_pkg::aorc_rest_t restore_o,
  output aorc_pkg::aorc_live_t retn_live_o,
  output logic busy_o
);
  import aorc_pkg::*;

  // ==========================================================
  // helpers
  // byte i of an image vector
  function automatic logic [7:0] img_byte(
    input logic [IMG_N*8-1:0] v, input logic [7:0] i);
    img_byte = v[i*8 +: 8];
  endfunction
  // retained bits of image byte i
  function automatic logic [7:0] keep(input logic [7:0] i);
    keep = img_byte(IMG_KEEP, i);
  endfunction
  localparam logic [7:0] LAST = 8'(IMG_N - 1);
  localparam logic [7:0] ENDI = 8'(IMG_N);

  // ==========================================================
  // state
  aorc_ctrl_t ctrl;
  logic [7:0] rd_addr;
  logic [7:0] rdat;
  aorc_state_t state;
  aorc_state_t next_state;
  logic [7:0] idx;
  logic rd_vld;
  logic [7:0] rd_idx;
  logic auto_save;
  logic auto_rest;
  logic upl_pulse;
  logic ram_en;
  logic ram_we;
  logic [7:0] ram_addr;
  logic [7:0] ram_wd;
  logic [7:0] ram_q;
  aorc_ctrl_t wr_val;
  logic wr_ctrl;
  logic wr_rdat;
  logic wr_addr;
  logic rest_go;
  logic save_go;
  logic read_go;
  logic clr_rest;
  logic clr_save;
  logic clr_read;

  // ==========================================================
  // bus decode
  assign wr_ctrl = bus_i.wr && (bus_i.addr == REG_CTRL);
  assign wr_rdat = bus_i.wr && (bus_i.addr == REG_RDAT);
  assign wr_addr = bus_i.wr && (bus_i.addr == REG_ADDR);
  assign wr_val = aorc_ctrl_t'(bus_i.wdata);
  // command launch terms, restore over save over read
  assign rest_go = ctrl.restore
    || (auto_rest && !ctrl.direct_access_enable);
  assign save_go = ctrl.save
    || (auto_save && !ctrl.direct_access_enable);
  assign read_go = ctrl.direct_read_cmd && ctrl.direct_access_enable;

  // hardware clears of the command bits
  assign clr_rest = (state == ST_RESTORE) && (idx == ENDI);
  assign clr_save = (state == ST_UPLOAD);
  assign clr_read = (state == ST_RDWAIT)
    || ((state == ST_IDLE) && !ctrl.direct_access_enable);

  // ==========================================================
  // sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (rest_go) begin
          next_state = ST_RESTORE;
        end else if (save_go) begin
          next_state = ST_SAVE;
        end else if (read_go) begin
          next_state = ST_RDWAIT;
        end
      end
      ST_SAVE: begin
        if (idx == LAST) begin
          next_state = ST_UPLOAD;
        end
      end
      ST_UPLOAD, ST_RDWAIT: begin
        next_state = ST_IDLE;
      end
      ST_RESTORE: begin
        if (idx == ENDI) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // image walk index
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      idx <= 8'h00;
    end else if (state == ST_SAVE || state == ST_RESTORE) begin
      idx <= idx + 8'h01;
    end else begin
      idx <= 8'h00;
    end
  end

  // ==========================================================
  // array port
  always_comb begin
    ram_en = 1'b0;
    ram_we = 1'b0;
    ram_addr = idx;
    // masked store drops every bit not in the retained set
    ram_wd = img_byte(user_cfg_i, idx) & keep(idx);
    if (state == ST_SAVE) begin
      ram_en = 1'b1;
      ram_we = 1'b1;
    end else if (state == ST_RESTORE && idx < ENDI) begin
      ram_en = 1'b1;
    end else if (state == ST_IDLE && next_state == ST_RDWAIT) begin
      ram_en = 1'b1;
      ram_addr = rd_addr;
    end
  end

  aorc_retention_array #(
    .WIDTH(DATA_W),
    .DEPTH(DEPTH),
    .AW(ADDR_W)
  ) u_array (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .en_i(ram_en),
    .we_i(ram_we),
    .addr_i(ram_addr),
    .wdata_i(ram_wd),
    .rdata_o(ram_q)
  );

  // ==========================================================
  // control register, a software write wins over the self-clear
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ctrl <= aorc_ctrl_t'(CTRL_RST);
    end else if (wr_ctrl) begin
      ctrl <= wr_val;
      ctrl.rsvd <= 3'h0; // reserved reads back as zero
    end else begin
      if (clr_rest) begin
        ctrl.restore <= 1'b0;
      end
      if (clr_save) begin
        ctrl.save <= 1'b0;
      end
      if (clr_read) begin
        ctrl.direct_read_cmd <= 1'b0;
      end
    end
  end

  // upload strobe on a write that sets the upload bit
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      upl_pulse <= 1'b0;
    end else begin
      upl_pulse <= wr_ctrl && wr_val.config_upload_cmd;
    end
  end

  // live always-on config words
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      retn_live_o <= '0;
    end else if (upl_pulse || state == ST_UPLOAD) begin
      retn_live_o.cfg0 <= retn_cfg0_i;
      retn_live_o.cfg1 <= retn_cfg1_i;
    end
  end

  // sleep and wake requests, dropped while direct access is on
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      auto_save <= 1'b0;
      auto_rest <= 1'b0;
    end else begin
      if (sleep_entry_i && !ctrl.direct_access_enable) begin
        auto_save <= 1'b1;
      end else if (state == ST_IDLE && next_state == ST_SAVE) begin
        auto_save <= 1'b0;
      end
      if (wake_i && !ctrl.direct_access_enable) begin
        auto_rest <= 1'b1;
      end else if (state == ST_IDLE && next_state == ST_RESTORE) begin
        auto_rest <= 1'b0;
      end
    end
  end

  // ==========================================================
  // direct access registers
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rd_addr <= ADDR_RST;
    end else if (wr_addr) begin
      rd_addr <= bus_i.wdata;
    end
  end

  // read data: loaded by a direct read, else by a bus write, else held
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rdat <= RDAT_RST;
    end else if (state == ST_RDWAIT) begin
      rdat <= ram_q;
    end else if (wr_rdat) begin
      rdat <= bus_i.wdata;
    end
  end

  // ==========================================================
  // restore write-back to host register set
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rd_vld <= 1'b0;
      rd_idx <= 8'h00;
    end else begin
      rd_vld <= (state == ST_RESTORE) && (idx < ENDI);
      rd_idx <= idx;
    end
  end

  // unkept bits return at reset value; tx antenna delay absent
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      restore_o <= '0;
    end else begin
      restore_o.we <= rd_vld;
      restore_o.idx <= rd_idx;
      restore_o.data <= (ram_q & keep(rd_idx))
        | (img_byte(IMG_RST, rd_idx)
        & ~keep(rd_idx));
    end
  end

  // ==========================================================
  // bus read answer, one cycle only
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rdata_o <= 8'h00;
    end else if (bus_i.rd) begin
      unique case (bus_i.addr)
        REG_CTRL: rdata_o <= ctrl;
        REG_RDAT: rdata_o <= rdat;
        REG_ADDR: rdata_o <= rd_addr;
        default: rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // busy flag
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= (next_state != ST_IDLE);
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (srst_i);
  sequence read_issue;
    state == ST_IDLE && next_state == ST_RDWAIT;
  endsequence
  sequence save_last;
    state == ST_SAVE && idx == LAST;
  endsequence
  a_read_lands: assert property (
    state == ST_RDWAIT |=> rdat == $past(ram_q))
    else $error("read data not loaded from array");
  a_read_gated: assert property (
    state == ST_IDLE && !ctrl.direct_access_enable |=> state != ST_RDWAIT)
    else $error("direct read ran while access disabled");
  a_read_bound: assert property (
    read_issue |=> state == ST_RDWAIT ##1 state == ST_IDLE)
    else $error("direct read took too long");
  a_rdat_hold: assert property (
    state != ST_RDWAIT && !wr_rdat |=> $stable(rdat))
    else $error("read data changed without a read");
  a_restore_clear: assert property (
    clr_rest && !wr_ctrl |=> !ctrl.restore)
    else $error("restore bit not cleared");
  a_save_upload: assert property (
    save_last |=> state == ST_UPLOAD
      ##1 (retn_live_o.cfg0 == $past(retn_cfg0_i) && !ctrl.save))
    else $error("save did not upload then clear");
  a_upl_sticky: assert property (
    ctrl.config_upload_cmd && !wr_ctrl |=> ctrl.config_upload_cmd)
    else $error("upload bit cleared by hardware");
  a_auto_gated: assert property (
    state == ST_IDLE && ctrl.direct_access_enable
      && !ctrl.restore && !ctrl.save
      |=> state == ST_IDLE || state == ST_RDWAIT)
    else $error("automatic transfer while access enabled");
  a_sniff_bit0: assert property (
    restore_o.we && restore_o.idx == 8'(SNIFF_BYTE)
      |-> !restore_o.data[0])
    else $error("sniff bit 0 restored as one");
  a_store_masked: assert property (
    ram_we |-> (ram_wd & ~keep(ram_addr)) == 8'h00)
    else $error("unretained bit stored");

endmodule
`default_nettype wire

// [hdl/aorc_pkg.sv]
package aorc_pkg;

  // ==========================================================
  // register map
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h02;
  localparam logic [7:0] REG_RDAT = 8'h03;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] RDAT_RST = 8'h00;
  localparam logic [7:0] ADDR_RST = 8'h00;

  // ==========================================================
  // retained image layout, one byte per array location
  localparam int IMG_BYTES = 24;
  localparam int ARR_DEPTH = 256;
  localparam int SNIFF_BYTE = 4;
  localparam int RD_LAT = 2;
  // bytes 0-3 tx frame ctl low word, 4-5 sniff, 6 frame_delimiter_length,
  // 7-9 power ctl first, 10-13 power ctl second,
  // 14 led ctl high byte, 15-23 other retained registers
  localparam logic [IMG_BYTES*8-1:0] IMG_KEEP =
    192'hFFFF_FFFF_FFFF_FFFF_FF01_03FF_FFFF_8098_40FF_FFFE_FFFF_FFFF;
  localparam logic [IMG_BYTES*8-1:0] IMG_RST = 192'h0;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic direct_access_enable;
    logic [2:0] rsvd;
    logic direct_read_cmd;
    logic config_upload_cmd;
    logic save;
    logic restore;
  } aorc_ctrl_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } aorc_req_t;

  typedef struct packed {
    logic we;
    logic [7:0] idx;
    logic [7:0] data;
  } aorc_rest_t;

  typedef struct packed {
    logic [31:0] cfg1;
    logic [31:0] cfg0;
  } aorc_live_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_SAVE = 5'h02,
    ST_UPLOAD = 5'h04,
    ST_RESTORE = 5'h08,
    ST_RDWAIT = 5'h10
  } aorc_state_t;

endpackage

// [hdl/aorc_retention_array.sv]
`timescale 1ns/1ps
`default_nettype none
module aorc_retention_array #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic en_i,
  input wire logic we_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  output logic [WIDTH-1:0] rdata_o
);

  // ==========================================================
  // storage, kept across sleep
  logic [WIDTH-1:0] mem [DEPTH];

  // write port
  always_ff @(posedge clock_i) begin
    if (en_i && we_i) begin
      mem[addr_i] <= wdata_i;
    end
  end

  // registered read, one cycle latency
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rdata_o <= '0;
    end else if (en_i && !we_i) begin
      rdata_o <= mem[addr_i];
    end
  end

endmodule
`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import aorc_pkg::*;
  // ==========================================================
  // stimulus, observed outputs and bookkeeping
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] w;
    logic [7:0] e;
  } aorc_row_t;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  aorc_req_t bus_i = '0;
  logic [IMG_BYTES*8-1:0] user_cfg_i = '0;
  logic [31:0] retn_cfg0_i = 32'h0000_0000;
  logic [31:0] retn_cfg1_i = 32'h0000_0000;
  logic sleep_entry_i = 1'b0;
  logic wake_i = 1'b0;
  logic [7:0] rdata_o;
  aorc_rest_t restore_o;
  aorc_live_t retn_live_o;
  logic busy_o;
  logic [IMG_BYTES*8-1:0] exp_img;
  logic [7:0] d;
  aorc_row_t rows [6];
  int n_mismatch = 0;
  int checks_done = 0;
  int n;

  // 125 MHz clock
  always #4 clock_i = ~clock_i;

  aorc_top aorc_top_i (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .bus_i(bus_i),
    .rdata_o(rdata_o),
    .user_cfg_i(user_cfg_i),
    .retn_cfg0_i(retn_cfg0_i),
    .retn_cfg1_i(retn_cfg1_i),
    .sleep_entry_i(sleep_entry_i),
    .wake_i(wake_i),
    .restore_o(restore_o),
    .retn_live_o(retn_live_o),
    .busy_o(busy_o)
  );

  // ==========================================================
  // comparison, bus cycles and sequencer wait
  task automatic chk(input string nm, input logic [63:0] got,
                     input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock_i);
    bus_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clock_i);
    bus_i <= '0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [7:0] e);
    @(posedge clock_i);
    bus_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock_i);
    bus_i <= '0;
    @(negedge clock_i);
    d = rdata_o;
    chk(nm, 64'(d), 64'(e));
  endtask

  // waits until the sequencer has idled a while, bounded
  task automatic run_wait(input bit collect);
    logic [7:0] e;
    int idle;
    n = 0;
    idle = 0;
    for (int i = 0; i < 100; i++) begin
      @(negedge clock_i);
      if (collect && restore_o.we === 1'b1) begin
        e = exp_img[8*n +: 8];
        chk("idx", 64'(restore_o.idx), 64'(n));
        chk("d", 64'(restore_o.data), 64'(e));
        n++;
      end
      idle = (busy_o === 1'b0) ? idle + 1 : 0;
      if (i > 2 && idle > 3) break;
    end
  endtask

  task automatic give_verdict();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // watchdog against a hung sequencer
  initial begin
    repeat (5000) @(posedge clock_i);
    n_mismatch++;
    give_verdict();
  end

  // ==========================================================
  // main sequence
  initial begin
    rows[0] = '{8'h02, 8'h70, 8'h00};
    rows[1] = '{8'h04, 8'h5A, 8'h5A};
    rows[2] = '{8'h03, 8'h33, 8'h33};
    rows[3] = '{8'h10, 8'hFF, 8'h00};
    rows[4] = '{8'h04, 8'h00, 8'h00};
    rows[5] = '{8'h03, 8'h00, 8'h00};
    for (int i = 0; i < IMG_BYTES; i++) begin
      user_cfg_i[8*i +: 8] <= 8'h81 + 8'(i);
    end
    repeat (10) @(posedge clock_i);
    srst_i <= 1'b0;
    rchk("ctrl rst", REG_CTRL, CTRL_RST);
    rchk("rdat rst", REG_RDAT, RDAT_RST);
    rchk("addr rst", REG_ADDR, ADDR_RST);
    // register table rows
    foreach (rows[k]) begin
      wr(rows[k].a, rows[k].w);
      rchk("row", rows[k].a, rows[k].e);
    end
    // upload command copies both words and stays set
    @(posedge clock_i);
    retn_cfg0_i <= 32'h1234_5678;
    retn_cfg1_i <= 32'h9ABC_DEF0;
    wr(REG_CTRL, 8'h04);
    repeat (2) @(posedge clock_i);
    @(negedge clock_i);
    chk("upload", retn_live_o, 64'h9ABC_DEF0_1234_5678);
    rchk("upl bit", REG_CTRL, 8'h04);
    // reset in mid-run clears live config and control
    @(posedge clock_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    @(negedge clock_i);
    chk("live rst", retn_live_o, 64'h0);
    chk("busy rst", 64'(busy_o), 64'h0);
    @(posedge clock_i);
    srst_i <= 1'b0;
    rchk("ctrl rst2", REG_CTRL, 8'h00);
    // save then upload, bit self-clears
    @(posedge clock_i);
    retn_cfg0_i <= 32'hCAFE_0001;
    retn_cfg1_i <= 32'h5555_AAAA;
    wr(REG_CTRL, 8'h02);
    run_wait(1'b0);
    chk("save live", retn_live_o, 64'h5555_AAAA_CAFE_0001);
    rchk("save bit", REG_CTRL, 8'h00);
    // restore must come from the array, not the live image
    exp_img = (user_cfg_i & IMG_KEEP) | (IMG_RST & ~IMG_KEEP);
    @(posedge clock_i);
    user_cfg_i <= ~user_cfg_i;
    wr(REG_CTRL, 8'h01);
    run_wait(1'b1);
    chk("restore n", 64'(n), 64'(IMG_BYTES));
    rchk("rest bit", REG_CTRL, 8'h00);
    // direct read of the sniff byte, bit 0 lost
    wr(REG_ADDR, 8'h04);
    wr(REG_CTRL, 8'h80);
    wr(REG_CTRL, 8'h88);
    repeat (3) @(posedge clock_i);
    rchk("rdat", REG_RDAT, exp_img[39:32]);
    rchk("dca bit", REG_CTRL, 8'h80);
    repeat (5) @(posedge clock_i);
    rchk("rdat hold", REG_RDAT, exp_img[39:32]);
    // direct read without enable has no effect
    wr(REG_CTRL, 8'h00);
    wr(REG_RDAT, 8'h77);
    wr(REG_CTRL, 8'h08);
    repeat (3) @(posedge clock_i);
    rchk("rdat gated", REG_RDAT, 8'h77);
    rchk("dca off", REG_CTRL, 8'h00);
    // wake while enabled is dropped
    wr(REG_CTRL, 8'h80);
    @(posedge clock_i);
    wake_i <= 1'b1;
    @(posedge clock_i);
    wake_i <= 1'b0;
    n = 0;
    repeat (10) @(negedge clock_i) if (busy_o !== 1'b0) n++;
    chk("wake drop", 64'(n), 64'h0);
    // sleep entry then wake with enable off
    wr(REG_CTRL, 8'h00);
    exp_img = (user_cfg_i & IMG_KEEP) | (IMG_RST & ~IMG_KEEP);
    @(posedge clock_i);
    retn_cfg0_i <= 32'h0F0F_0F0F;
    sleep_entry_i <= 1'b1;
    @(posedge clock_i);
    sleep_entry_i <= 1'b0;
    run_wait(1'b0);
    chk("auto save", retn_live_o, 64'h5555_AAAA_0F0F_0F0F);
    @(posedge clock_i);
    wake_i <= 1'b1;
    @(posedge clock_i);
    wake_i <= 1'b0;
    run_wait(1'b1);
    chk("auto rest", 64'(n), 64'(IMG_BYTES));
    give_verdict();
  end
endmodule
`default_nettype wire
